// ==== core/pbsc_sram.sv ====
// Summary of operation
// (RQ1) global write low writes both lanes, ignoring byte write controls.
// (RQ2) byte write enable low writes only lanes whose select is low.
// (RQ3) write means global low, or byte enable low with a lane select low.
// (RQ4) output enable is asynchronous; lanes drive when low, float when high.
// (RQ5) controller keeps output enable high around writes that follow reads.
// (RQ6) linear order counts the two low bits upward, wrapping at four.
// (RQ7) interleaved order XORs the start bits with 0,1,2,3 in turn.
// (RQ8) strobe start without all chip enables deselects and floats lanes.
// (RQ9) selected processor strobe, or controller strobe without write, begins read.
// (RQ10) selected controller strobe with write, processor strobe high, begins write.
// (RQ11) no start, advance high, write asserted: write at current address.
// (RQ12) no start, advance low: step counter, read or write there.
// (RQ13) no start, advance high, no write: repeat read at current address.
// (RQ14) primary enable high makes the processor strobe ignored.
// (RQ15) depth enable low select must be low for a start to select.
// (RQ16) lanes float during writes and during a read's first cycle.
// (RQ17) burst order select is static: low linear, high interleaved.
// (RQ18) read data pass an output register, one cycle of latency.
// (RQ19) controller wires bus address LSBs to the two low address inputs.
// (RQ20) counter changes only the two low bits; upper bits stay fixed.
// (RQ21) array holds 65536 words of 18 bits in two 9-bit lanes.
module pbsc_sram #(
    parameter int ADDR_W = pbsc_pkg::PBSC_ADDR_W,
    parameter int LANE_W = pbsc_pkg::PBSC_LANE_W
) (
    // clock, reset, enable
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire logic                  ce,
    // chip enables and strobes
    input  wire logic                  chip_enable_primary_n,
    input  wire logic                  depth_enable_high,
    input  wire logic                  depth_enable_low_n,
    input  wire logic                  proc_addr_strobe_n,
    input  wire logic                  ctrl_addr_strobe_n,
    input  wire logic                  burst_advance_n,
    input  wire logic                  burst_order_select,
    // write controls
    input  wire logic                  global_write_n,
    input  wire logic                  byte_write_enable_n,
    input  wire logic                  byte_a_write_n,
    input  wire logic                  byte_b_write_n,
    input  wire logic                  output_enable_n,
    // address and data lanes
    input  wire logic [ADDR_W-1:0]     addr_inputs,
    input  wire logic [2*LANE_W-1:0]   data_lanes_in,
    output logic      [2*LANE_W-1:0]   data_lanes_out,
    output logic                       data_lanes_oe,
    // axi4-lite write address and data
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready
);
    import pbsc_pkg::*;

    // elaboration check on shape
    if (ADDR_W < 3 || ADDR_W > 30 || LANE_W < 1 || LANE_W > 16) begin : g_bad_param
        $error("pbsc_sram: unsupported ADDR_W or LANE_W");
    end

    localparam int DEPTH = 1 << ADDR_W;

    // burst address for a given step, in either order
    function automatic logic [1:0] burst_low(input logic [1:0] base, input logic [1:0] step,
                                             input logic order);
        burst_low = order ? (base ^ step) : 2'(base + step);
    endfunction

    // (RQ21) two-lane word array
    logic [2*LANE_W-1:0] mem [DEPTH];

    logic                 active_r;
    logic [ADDR_W-3:0]    upper_r;
    logic [1:0]           base_r;
    logic [1:0]           cnt_r;
    logic                 rd_pend_r;
    logic [ADDR_W-1:0]    rd_addr_r;
    logic                 out_valid_r;
    logic [2*LANE_W-1:0]  dout_r;
    logic                 ctrl_en_r;
    logic [31:0]          wr_count_r;

    // start and select decode
    wire  sel_all  = ~chip_enable_primary_n & depth_enable_high & ~depth_enable_low_n;
    // (RQ14) processor strobe blocked
    wire  start_p  = ~proc_addr_strobe_n & ~chip_enable_primary_n;
    wire  start_c  = ~ctrl_addr_strobe_n & ~start_p;
    wire  start    = start_p | start_c;
    // (RQ15) depth select gates starts
    wire  sel_ok   = sel_all & ctrl_en_r;

    // (RQ1) global write takes both lanes
    wire  wr_a     = ~global_write_n | (~byte_write_enable_n & ~byte_a_write_n);
    // (RQ2) byte lanes by select
    wire  wr_b     = ~global_write_n | (~byte_write_enable_n & ~byte_b_write_n);
    // (RQ3) write versus read
    wire  wr_req   = wr_a | wr_b;

    // (RQ17) order taken straight from the static pin
    wire  [1:0] cur_low  = burst_low(base_r, cnt_r, burst_order_select);
    wire  [1:0] next_low = burst_low(base_r, 2'(cnt_r + 2'h1), burst_order_select);

    // cycle kind, starts first, then burst control
    pbsc_kind_t kind;
    always_comb begin
        kind = PBSC_IDLE;
        if (start) begin
            // (RQ8) deselect on a start without full select
            if (!sel_ok) begin
                kind = PBSC_DESEL;
            // (RQ9) processor strobe reads
            end else if (start_p || !wr_req) begin
                kind = PBSC_RD_EXT;
            // (RQ10) controller strobe with write
            end else begin
                kind = PBSC_WR_EXT;
            end
        end else if (active_r) begin
            // (RQ12) advance low steps the burst
            if (!burst_advance_n) begin
                kind = wr_req ? PBSC_WR_NEXT : PBSC_RD_NEXT;
            // (RQ11) (RQ13) hold address, write or repeat read
            end else begin
                kind = wr_req ? PBSC_WR_CUR : PBSC_RD_CUR;
            end
        end
    end

    wire is_ext   = (kind == PBSC_RD_EXT) || (kind == PBSC_WR_EXT);
    wire is_next  = (kind == PBSC_RD_NEXT) || (kind == PBSC_WR_NEXT);
    wire is_read  = (kind == PBSC_RD_EXT) || (kind == PBSC_RD_NEXT) || (kind == PBSC_RD_CUR);
    wire is_write = (kind == PBSC_WR_EXT) || (kind == PBSC_WR_NEXT) || (kind == PBSC_WR_CUR);

    // (RQ20) only the low two bits come from the counter
    wire [ADDR_W-1:0] eff_addr = is_ext  ? addr_inputs :
                                 is_next ? {upper_r, next_low} : {upper_r, cur_low};
    wire [1:0]        lane_we  = is_write ? {wr_b, wr_a} : 2'h0;

    // burst state and read pipeline
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            active_r    <= 1'b0;
            upper_r     <= '0;
            base_r      <= 2'h0;
            cnt_r       <= 2'h0;
            rd_pend_r   <= 1'b0;
            rd_addr_r   <= '0;
            out_valid_r <= 1'b0;
        end else if (ce) begin
            if (kind == PBSC_DESEL) begin
                active_r <= 1'b0;
            end else if (is_ext) begin
                active_r <= 1'b1;
                upper_r  <= addr_inputs[ADDR_W-1:2];
                base_r   <= addr_inputs[1:0];
                cnt_r    <= 2'h0;
            // (RQ6) (RQ7) step count for the next address
            end else if (is_next) begin
                cnt_r    <= 2'(cnt_r + 2'h1);
            end
            rd_pend_r   <= is_read;
            rd_addr_r   <= eff_addr;
            // (RQ18) data reach output one edge after the access
            out_valid_r <= rd_pend_r;
        end
    end

    // output data register, cleared to zero by reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dout_r <= '0;
        end else if (ce && rd_pend_r) begin
            dout_r <= mem[rd_addr_r];
        end
    end

    // (RQ2) self-timed lane writes at the edge
    always_ff @(posedge clk) begin
        if (ce && lane_we[0]) begin
            mem[eff_addr][LANE_W-1:0] <= data_lanes_in[LANE_W-1:0];
        end
        if (ce && lane_we[1]) begin
            mem[eff_addr][2*LANE_W-1:LANE_W] <= data_lanes_in[2*LANE_W-1:LANE_W];
        end
    end

    // (RQ4) (RQ16) drive only with valid read data and enable low
    assign data_lanes_out = dout_r;
    assign data_lanes_oe  = out_valid_r & ~output_enable_n;

    // ---------------- register slave ----------------
    logic        aw_got_r;
    logic [7:0]  aw_addr_r;
    logic        w_got_r;
    logic [31:0] w_data_r;
    logic        w_strb0_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;

    // handshake readies
    assign s_axi_awready = ce & ~aw_got_r & ~bvalid_r;
    assign s_axi_wready  = ce & ~w_got_r & ~bvalid_r;
    assign s_axi_arready = ce & ~rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    wire wr_go      = aw_got_r & w_got_r & ~bvalid_r;
    wire wr_ctrl    = wr_go && (aw_addr_r == PBSC_CTRL_OFS);
    wire wr_ok      = (aw_addr_r == PBSC_CTRL_OFS) || (aw_addr_r == PBSC_STATUS_OFS) ||
                      (aw_addr_r == PBSC_WRCNT_OFS);

    // read data selection
    logic [31:0] rd_mux;
    logic        rd_hit;
    always_comb begin
        rd_mux = 32'h0;
        rd_hit = 1'b1;
        if (s_axi_araddr == PBSC_CTRL_OFS) begin
            rd_mux[PBSC_CTRL_EN_BIT] = ctrl_en_r;
        end else if (s_axi_araddr == PBSC_STATUS_OFS) begin
            rd_mux[PBSC_ST_ACT_BIT]  = active_r;
            rd_mux[PBSC_ST_PEND_BIT] = rd_pend_r;
            rd_mux[PBSC_ST_ADDR_LSB +: ADDR_W] = {upper_r, cur_low};
        end else if (s_axi_araddr == PBSC_WRCNT_OFS) begin
            rd_mux = wr_count_r;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // write channel capture and response
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_got_r  <= 1'b0;
            aw_addr_r <= 8'h00;
            w_got_r   <= 1'b0;
            w_data_r  <= 32'h0;
            w_strb0_r <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= PBSC_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r  <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r   <= 1'b1;
                w_data_r  <= s_axi_wdata;
                w_strb0_r <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r  <= wr_ok ? PBSC_RESP_OKAY : PBSC_RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // read channel
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0;
            rresp_r  <= PBSC_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_r <= 1'b1;
                rdata_r  <= rd_mux;
                rresp_r  <= rd_hit ? PBSC_RESP_OKAY : PBSC_RESP_SLVERR;
            end else if (rvalid_r && s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // control enable and write-cycle counter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_en_r  <= PBSC_CTRL_EN_RST;
            wr_count_r <= 32'h0;
        end else if (ce) begin
            if (wr_ctrl && w_strb0_r) begin
                ctrl_en_r <= w_data_r[PBSC_CTRL_EN_BIT];
            end
            if (wr_go && (aw_addr_r == PBSC_WRCNT_OFS) && w_strb0_r) begin
                wr_count_r <= 32'h0;
            end else if (is_write) begin
                wr_count_r <= wr_count_r + 32'h1;
            end
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_rd_start;
        ce && (kind == PBSC_RD_EXT);
    endsequence

    a_read_latency: assert property ( // (RQ18)
        s_rd_start ##1 ce |=> out_valid_r && $past(rd_pend_r))
        else $error("read data not valid one edge after read start");
    // an earlier read may still stream its data; only a start with nothing pending floats
    a_first_cycle_float: assert property ( // (RQ16)
        s_rd_start ##0 !rd_pend_r |=> !out_valid_r)
        else $error("lanes driven in first cycle of read");
    a_write_float: assert property ( // (RQ16)
        (ce && is_write) ##1 ce |=> !out_valid_r)
        else $error("lanes valid after a write cycle");
    // a start right after the deselect may reactivate the burst, so look one edge back
    a_desel_float: assert property ( // (RQ8)
        (ce && kind == PBSC_DESEL) ##1 ce |=> !out_valid_r && !$past(active_r))
        else $error("deselect did not float lanes");
    a_oe_async: assert property ( // (RQ4)
        output_enable_n |-> !data_lanes_oe)
        else $error("lanes driven with output enable high");
    a_linear_step: assert property ( // (RQ6)
        (ce && is_next && !burst_order_select) |=> cur_low == 2'($past(cur_low) + 2'h1))
        else $error("linear burst step wrong");
    a_inter_step: assert property ( // (RQ7)
        (ce && is_next && burst_order_select) |=>
            cur_low == ($past(base_r) ^ 2'($past(cnt_r) + 2'h1)))
        else $error("interleaved burst step wrong");
    a_suspend_hold: assert property ( // (RQ13)
        (ce && kind == PBSC_RD_CUR) |=> cur_low == $past(cur_low) && $stable(upper_r))
        else $error("suspend moved the burst address");
    a_upper_fixed: assert property ( // (RQ20)
        (ce && !start && active_r) |=> $stable(upper_r))
        else $error("upper address changed inside burst");
    a_global_both: assert property ( // (RQ1)
        (!global_write_n && is_write) |-> lane_we == 2'h3)
        else $error("global write missed a lane");
    a_proc_read: assert property ( // (RQ9)
        (start_p && sel_ok) |-> kind == PBSC_RD_EXT)
        else $error("processor strobe did not begin read");
    a_ignore_proc: assert property ( // (RQ14)
        (chip_enable_primary_n && ctrl_addr_strobe_n) |-> !start)
        else $error("processor strobe not ignored");

endmodule // pbsc_sram

// ==== core/pbsc_pkg.sv ====
package pbsc_pkg;

    // array shape
    localparam int          PBSC_LANE_W      = 9;
    localparam int          PBSC_ADDR_W      = 16;
    localparam int          PBSC_BURST_LEN   = 4;

    // register byte offsets
    localparam logic [7:0]  PBSC_CTRL_OFS    = 8'h00;
    localparam logic [7:0]  PBSC_STATUS_OFS  = 8'h04;
    localparam logic [7:0]  PBSC_WRCNT_OFS   = 8'h08;

    // field positions
    localparam int          PBSC_CTRL_EN_BIT = 0;
    localparam int          PBSC_ST_ACT_BIT  = 0;
    localparam int          PBSC_ST_PEND_BIT = 1;
    localparam int          PBSC_ST_ADDR_LSB = 2;

    // values after reset
    localparam logic        PBSC_CTRL_EN_RST = 1'b1;

    // bus answers
    localparam logic [1:0]  PBSC_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  PBSC_RESP_SLVERR = 2'h2;

    // cycle kinds decided at each enabled edge
    typedef enum logic [2:0] {
        PBSC_IDLE,
        PBSC_DESEL,
        PBSC_RD_EXT,
        PBSC_WR_EXT,
        PBSC_RD_NEXT,
        PBSC_WR_NEXT,
        PBSC_RD_CUR,
        PBSC_WR_CUR
    } pbsc_kind_t;

endpackage : pbsc_pkg

// ==== verif/pbsc_ctrl_model.sv ====
module pbsc_ctrl_model (
    // clock
    input  wire logic   clk,
    // selects and strobes
    output logic        chip_enable_primary_n,
    output logic        depth_enable_high,
    output logic        depth_enable_low_n,
    output logic        proc_addr_strobe_n,
    output logic        ctrl_addr_strobe_n,
    output logic        burst_advance_n,
    output logic        burst_order_select,
    // write controls
    output logic        global_write_n,
    output logic        byte_write_enable_n,
    output logic        byte_a_write_n,
    output logic        byte_b_write_n,
    output logic        output_enable_n,
    // address and data
    output logic [15:0] addr_inputs,
    output logic [17:0] data_lanes_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] sel_q;   // chip enables staged for the next cycle
    logic       wr_prev; // last cycle was a write

    // quiet bus at time zero
    initial begin
        sel_q = 3'b010;
        wr_prev = 1'b0;
        {chip_enable_primary_n, depth_enable_high, depth_enable_low_n} = 3'b010;
        {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = 3'b111;
        {global_write_n, byte_write_enable_n, byte_a_write_n, byte_b_write_n} = 4'hf;
        burst_order_select = 1'b0;
        output_enable_n = 1'b1;
        addr_inputs = 16'h0000;
        data_lanes_in = 18'h00000;
    end

    // order pin moves only after a deselect, so no live burst sees it change
    task automatic order(input logic o);
        @(posedge clk);
        {chip_enable_primary_n, depth_enable_high, depth_enable_low_n} <= 3'b110;
        {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} <= 3'b101;
        {global_write_n, byte_write_enable_n, byte_a_write_n, byte_b_write_n} <= 4'hf;
        @(posedge clk);
        {chip_enable_primary_n, depth_enable_high, depth_enable_low_n} <= sel_q;
        {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} <= 3'b111;
        burst_order_select <= o;
    endtask

    // one bus cycle, taken at the following edge
    task automatic cyc(input logic p, c, a, input logic [3:0] w,
                       input logic [15:0] ad, input logic [17:0] d);
        logic wr;
        wr = !w[3] || (!w[2] && !(w[1] && w[0]));
        @(posedge clk);
        {chip_enable_primary_n, depth_enable_high, depth_enable_low_n} <= sel_q;
        {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} <= {p, c, a};
        {global_write_n, byte_write_enable_n, byte_a_write_n, byte_b_write_n} <= w;
        // bus low bits on the counter inputs
        addr_inputs <= ad;
        data_lanes_in <= wr ? d : ~data_lanes_in; // released lanes do not hold
        // output enable off during writes and for one cycle after
        output_enable_n <= wr || wr_prev;
        wr_prev = wr;
    endtask

    // output enable moved away from any edge
    task automatic oe_async(input logic v);
        #2 output_enable_n = v;
        #1;
    endtask
endmodule // pbsc_ctrl_model

// ==== verif/pipelined_burst_sram_control_tb.sv ====
module pipelined_burst_sram_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pbsc_pkg::*;

    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        ce = 1'b1;
    logic        chip_enable_primary_n, depth_enable_high, depth_enable_low_n;
    logic        proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n;
    logic        burst_order_select, global_write_n, byte_write_enable_n;
    logic        byte_a_write_n, byte_b_write_n, output_enable_n;
    logic [15:0] addr_inputs;
    logic [17:0] data_lanes_in, data_lanes_out;
    logic        data_lanes_oe;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    int          n_mismatch = 0;
    int          tests_run = 0;

    // 100 MHz clock
    always #5 clk = ~clk;

    pbsc_sram u_dut (.clk, .arst_n, .ce, .chip_enable_primary_n, .depth_enable_high,
        .depth_enable_low_n, .proc_addr_strobe_n, .ctrl_addr_strobe_n, .burst_advance_n,
        .burst_order_select, .global_write_n, .byte_write_enable_n, .byte_a_write_n,
        .byte_b_write_n, .output_enable_n, .addr_inputs, .data_lanes_in, .data_lanes_out,
        .data_lanes_oe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    pbsc_ctrl_model u_host (.clk, .chip_enable_primary_n, .depth_enable_high,
        .depth_enable_low_n, .proc_addr_strobe_n, .ctrl_addr_strobe_n, .burst_advance_n,
        .burst_order_select, .global_write_n, .byte_write_enable_n, .byte_a_write_n,
        .byte_b_write_n, .output_enable_n, .addr_inputs, .data_lanes_in);

    // value and flag comparisons
    task automatic chk_val(input string nm, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask

    // register write: address and data offered together, each released when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_t, w_t, b_t;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clk);
            aw_t = s_axi_awvalid && s_axi_awready;
            w_t = s_axi_wvalid && s_axi_wready;
            b_t = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
        end while (!b_t);
        s_axi_bready <= 1'b0;
    endtask

    // register read
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_t, r_t;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge clk);
            ar_t = s_axi_arvalid && s_axi_arready;
            r_t = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (ar_t) s_axi_arvalid <= 1'b0;
        end while (!r_t);
        s_axi_rready <= 1'b0;
    endtask

    // reset values, unmapped and read-only places
    task automatic t_regs();
        axi_rd(PBSC_CTRL_OFS, rd, rs);
        chk_bit("ctrl enable", PBSC_CTRL_EN_RST, rd[PBSC_CTRL_EN_BIT]);
        axi_rd(8'h0c, rd, rs);
        chk_val("unmapped resp", 32'(PBSC_RESP_SLVERR), 32'(rs));
        chk_val("unmapped data", 32'h0, rd);
        axi_wr(PBSC_STATUS_OFS, 32'hffffffff, rs);
        chk_val("status write resp", 32'(PBSC_RESP_OKAY), 32'(rs));
    endtask

    // global, byte and null writes, then a read that outranks a write
    task automatic t_single();
        u_host.cyc(1'b1, 1'b0, 1'b1, 4'b0111, 16'h1234, 18'h2a5a5);
        u_host.cyc(1'b1, 1'b0, 1'b1, 4'b1001, 16'h1234, 18'h3ffff);
        u_host.cyc(1'b1, 1'b0, 1'b1, 4'b1011, 16'h1234, 18'h00000);
        u_host.cyc(1'b0, 1'b0, 1'b1, 4'b0111, 16'h1234, 18'h00000);
        repeat (2) u_host.cyc(1'b1, 1'b1, 1'b1, 4'hf, 16'h0000, 18'h0);
        #1 chk_val("lane data", 32'h2a5ff, 32'(data_lanes_out));
        chk_bit("lanes driven", 1'b1, data_lanes_oe);
        u_host.oe_async(1'b1);
        chk_bit("lanes off", 1'b0, data_lanes_oe);
    endtask

    // burst write: current-address write, then three continues
    task automatic t_bwrite();
        axi_wr(PBSC_WRCNT_OFS, 32'h1, rs);
        u_host.order(1'b0);
        u_host.cyc(1'b1, 1'b0, 1'b1, 4'b0111, 16'h5a30, 18'h3ffff);
        u_host.cyc(1'b1, 1'b1, 1'b1, 4'b0111, 16'hffff, 18'h00100);
        for (int i = 1; i < 4; i++) begin
            u_host.cyc(1'b1, 1'b1, 1'b0, 4'b1000, 16'hffff, 18'h100 + 18'(i));
        end
        u_host.cyc(1'b1, 1'b1, 1'b1, 4'hf, 16'h0000, 18'h0);
        axi_rd(PBSC_WRCNT_OFS, rd, rs);
        chk_val("write count", 32'd5, rd);
        axi_rd(PBSC_STATUS_OFS, rd, rs);
        chk_val("burst status", (32'h5a33 << PBSC_ST_ADDR_LSB) | 32'h3, rd);
    endtask

    // burst read from start s; pn raises the primary enable during continues
    task automatic t_burst(input logic o, input logic [1:0] s, input logic pn);
        logic [1:0] a;
        u_host.order(o);
        u_host.cyc(1'b1, 1'b0, 1'b1, 4'hf, {14'h168c, s}, 18'h0);
        u_host.sel_q = {pn, 2'b10};
        u_host.cyc(~pn, 1'b1, 1'b0, 4'hf, 16'h0000, 18'h0);
        for (int i = 0; i < 4; i++) begin
            a = o ? s ^ 2'(i) : s + 2'(i);
            u_host.cyc(~pn, 1'b1, 1'b0, 4'hf, 16'h0000, 18'h0);
            #1 chk_val("burst data", 32'(18'h100 + 18'(a)), 32'(data_lanes_out));
        end
        u_host.sel_q = 3'b010;
    endtask

    // deselecting starts: {enables, proc strobe, ctrl strobe}; last one with ctrl off
    task automatic t_desel();
        logic [4:0] tbl [5] = '{5'b11000, 5'b01101, 5'b00001, 5'b01110, 5'b01010};
        for (int k = 0; k < 5; k++) begin
            if (k == 4) axi_wr(PBSC_CTRL_OFS, 32'h0, rs);
            u_host.cyc(1'b0, 1'b1, 1'b1, 4'hf, 16'h0040, 18'h0);
            u_host.sel_q = tbl[k][4:2];
            u_host.cyc(tbl[k][1], tbl[k][0], 1'b1, 4'hf, 16'h0040, 18'h0);
            u_host.sel_q = 3'b010;
            repeat (2) u_host.cyc(1'b1, 1'b1, 1'b1, 4'hf, 16'h0040, 18'h0);
            #1 chk_bit("lanes float", 1'b0, data_lanes_oe);
        end
        axi_wr(PBSC_CTRL_OFS, 32'h1, rs);
    endtask

    // counts and verdict
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        t_regs();
        t_single();
        t_bwrite();
        t_burst(1'b0, 2'b01, 1'b0);
        t_burst(1'b1, 2'b10, 1'b1);
        t_burst(1'b0, 2'b11, 1'b1);
        t_burst(1'b1, 2'b01, 1'b0);
        t_desel();
        wrap_up();
    end

    // hang guard, well beyond the hundred or so cycles the tests take
    initial begin
        #100us;
        n_mismatch++;
        wrap_up();
    end
endmodule // pipelined_burst_sram_control_tb
